/* File: rtl/hltc_core.sv */
// Contract
// RL1: harmonic number is IF delta over twelve steps
// RL2: coarse product is twelve times N times oscillator
// RL3: centre filter on first IF, convert to BCD
// RL4: input estimate is coarse plus/minus filter frequency
// RL5: corrected oscillator from estimate, then retune, recentre
// RL6: shallow search exits at once on signal
// RL7: search plus/minus 60 MHz RF, 200 kHz steps
// RL8: tracking keeps second IF between 115 and 135
// RL9: tracking without threshold returns, locking restarts
// RL10: tracking reads IF, retunes oscillator and filter
// RL11: offset is oscillator times twelve N plus/minus two
// RL12: filter is twice oscillator plus 125 MHz
// RL13: oscillator set only on 50 kHz grid
// RL14: program word from frequency times five, fraction
// RL15: upper digits to 9822, lower to 9820
// RL16: locking starts on select, threshold loss, reset
// RL17: oscillator never above 500 MHz
// RL18: one mixing sign used in every term
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module hltc_core
  import hltc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        if_threshold_i,
  output logic      [15:0] prog_addr_o,
  output logic      [7:0]  prog_data_o,
  output logic             prog_we_o,
  output logic      [31:0] filter_freq_o,
  output logic             filter_we_o,
  output logic             supervisor_o
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_HARM, ST_CENTRE, ST_FIN, ST_VCO, ST_TUNE, ST_PHI, ST_PLO,
    ST_SETTLE, ST_SHALLOW, ST_SEARCH, ST_LOCALC, ST_LOCKED, ST_TRACK
  } hltc_state_t;

  logic        thr_meta_reg, thr_sync_reg;
  logic        ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic        sign_reg, sign_next;
  logic [31:0] step_reg, step_next;
  logic [31:0] ifd_reg, ifd_next;
  logic [31:0] vsw_reg, vsw_next;
  logic [31:0] if2_reg, if2_next;
  logic        start_reg, start_next;
  logic        trk_reg, trk_next;
  logic        start_take, trk_take;

  hltc_state_t state_reg, state_next, ret_reg, ret_next;
  logic [7:0]  harm_reg, harm_next;
  logic [31:0] vco_reg, vco_next;
  logic [31:0] coarse_reg, coarse_next;
  logic [31:0] fin_reg, fin_next;
  logic [31:0] tgt_reg, tgt_next;
  logic [31:0] filt_reg, filt_next;
  logic [31:0] fbcd_reg, fbcd_next;
  logic [31:0] lo_reg, lo_next;
  logic [31:0] off_reg, off_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        locked_reg, locked_next, lost_reg, lost_next, fail_reg, fail_next;
  logic [15:0] padr_reg, padr_next;
  logic [7:0]  pdat_reg, pdat_next;
  logic        pwe_reg, pwe_next, fwe_reg, fwe_next, sup_reg, sup_next;

  logic [31:0] div_w, div_safe, vco_try, step12, prog_word32;
  logic [15:0] prog_word;
  logic        bus_req;

  hltc_prog_word u_word (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .freq_khz_i (vco_reg),
    .word_o     (prog_word)
  );

  assign bus_req     = wb_cyc_i && wb_stb_i && !ack_reg;
  assign prog_word32 = {16'h0000, prog_word};

  // register bus: one wait state, ack drops the cycle after it is given
  always_comb begin
    ack_next   = bus_req;
    dat_next   = REG_RESET;
    sign_next  = sign_reg;
    step_next  = step_reg;
    ifd_next   = ifd_reg;
    vsw_next   = vsw_reg;
    if2_next   = if2_reg;
    start_next = start_take ? 1'b0 : start_reg;
    trk_next   = trk_take ? 1'b0 : trk_reg;
    if (bus_req && wb_we_i) begin
      unique case (wb_adr_i)
        ADR_CTRL: begin
          if (wb_sel_i[0]) begin
            sign_next = wb_dat_i[CTRL_SIGN];
            if (wb_dat_i[CTRL_START]) begin
              start_next = 1'b1;                                         // [RL16]
            end
          end
        end
        ADR_STEP:    step_next = hltc_wmask(step_reg, wb_dat_i, wb_sel_i);
        ADR_IFDELTA: ifd_next = hltc_wmask(ifd_reg, wb_dat_i, wb_sel_i);
        ADR_VCO:     vsw_next = hltc_wmask(vsw_reg, wb_dat_i, wb_sel_i);
        ADR_TRACKIF: begin
          if2_next = hltc_wmask(if2_reg, wb_dat_i, wb_sel_i);
          trk_next = 1'b1;
        end
        default: ;
      endcase
    end else if (bus_req) begin
      unique case (wb_adr_i)
        ADR_CTRL:    dat_next = {30'h0, sign_reg, start_reg};
        ADR_STEP:    dat_next = step_reg;
        ADR_IFDELTA: dat_next = ifd_reg;
        ADR_VCO:     dat_next = vco_reg;
        ADR_TRACKIF: dat_next = if2_reg;
        ADR_STATUS:  dat_next = {28'h0, fail_reg, (state_reg != ST_IDLE), lost_reg, locked_reg};
        ADR_HARM:    dat_next = {24'h0, harm_reg};
        ADR_LO:      dat_next = lo_reg;
        ADR_FILTBCD: dat_next = fbcd_reg;
        default:     dat_next = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= REG_RESET;
      sign_reg <= 1'b0;
      step_reg <= REG_RESET;
      ifd_reg <= REG_RESET;
      vsw_reg <= REG_RESET;
      if2_reg <= REG_RESET;
      start_reg <= 1'b1;
      trk_reg <= 1'b0;
      thr_meta_reg <= 1'b0;
      thr_sync_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      sign_reg <= sign_next;
      step_reg <= step_next;
      ifd_reg <= ifd_next;
      vsw_reg <= vsw_next;
      if2_reg <= if2_next;
      start_reg <= start_next;
      trk_reg <= trk_next;
      thr_meta_reg <= if_threshold_i;
      thr_sync_reg <= thr_meta_reg;
    end
  end

  // sign_reg is loaded on every CTRL write with byte lane 0 selected, start bit or not, and feeds every +/- term
  always_comb begin
    div_w    = hltc_harm_div(harm_reg, sign_reg);                        // [RL18]
    div_safe = (div_w == 32'h0) ? 32'h1 : div_w;
    vco_try  = hltc_round50(32'((sign_reg ? 32'(tgt_reg + IF2_NOM_KHZ)
                                          : 32'(tgt_reg - IF2_NOM_KHZ)) / div_safe)); // [RL5] [RL13]
    step12   = 32'(step_reg * HARM_FACTOR);
  end

  always_comb begin
    state_next  = state_reg;
    ret_next    = ret_reg;
    harm_next   = harm_reg;
    vco_next    = vco_reg;
    coarse_next = coarse_reg;
    fin_next    = fin_reg;
    tgt_next    = tgt_reg;
    filt_next   = filt_reg;
    fbcd_next   = fbcd_reg;
    lo_next     = lo_reg;
    off_next    = off_reg;
    cnt_next    = cnt_reg;
    locked_next = locked_reg;
    lost_next   = lost_reg;
    fail_next   = fail_reg;
    padr_next   = padr_reg;
    pdat_next   = pdat_reg;
    pwe_next    = 1'b0;
    fwe_next    = 1'b0;
    sup_next    = 1'b0;
    start_take  = 1'b0;
    trk_take    = 1'b0;
    if (start_reg) begin
      start_take  = 1'b1;                                                 // [RL16]
      vco_next    = vsw_reg;
      locked_next = 1'b0;
      fail_next   = 1'b0;
      lost_next   = 1'b0;
      state_next  = ST_HARM;
    end else begin
      unique case (state_reg)
        ST_IDLE: ;
        ST_HARM: begin
          harm_next = 8'(32'(ifd_reg + (step12 >> 1)) / ((step12 == 32'h0) ? 32'h1 : step12)); // [RL1]
          coarse_next = 32'(32'(harm_next * HARM_FACTOR) * vco_reg);     // [RL2]
          state_next = ST_CENTRE;
          if (step12 == 32'h0 || harm_next == 8'h00) begin
            fail_next  = 1'b1;
            sup_next   = 1'b1;
            state_next = ST_IDLE;
          end
        end
        ST_CENTRE: begin
          filt_next  = 32'(32'(vco_reg << 1) + IF2_NOM_KHZ);              // [RL3]
          fbcd_next  = hltc_bin_to_bcd(filt_next);                        // [RL3]
          fwe_next   = 1'b1;
          state_next = ST_FIN;
        end
        ST_FIN: begin
          fin_next   = sign_reg ? 32'(coarse_reg + hltc_bcd_to_bin(fbcd_reg))
                                : 32'(coarse_reg - hltc_bcd_to_bin(fbcd_reg)); // [RL4] [RL18]
          tgt_next   = fin_next;
          ret_next   = ST_SHALLOW;
          state_next = ST_VCO;
        end
        ST_VCO: begin
          if (vco_try == 32'h0 || vco_try > VCO_MAX_KHZ) begin            // [RL17]
            fail_next   = 1'b1;
            locked_next = 1'b0;
            sup_next    = 1'b1;
            state_next  = ST_IDLE;
          end else begin
            vco_next   = vco_try;                                         // [RL5] [RL10]
            filt_next  = 32'(32'(vco_try << 1) + IF2_NOM_KHZ);            // [RL12]
            fbcd_next  = hltc_bin_to_bcd(filt_next);
            fwe_next   = 1'b1;                                            // [RL10]
            state_next = ST_TUNE;
          end
        end
        ST_TUNE: state_next = ST_PHI;  // word module needs one edge to follow vco_reg
        ST_PHI: begin
          padr_next  = PROG_ADR_HIGH;                                     // [RL15]
          pdat_next  = prog_word32[15:8];
          pwe_next   = 1'b1;
          state_next = ST_PLO;
        end
        ST_PLO: begin
          padr_next  = PROG_ADR_LOW;                                      // [RL15]
          pdat_next  = prog_word32[7:0];
          pwe_next   = 1'b1;
          cnt_next   = 16'(SETTLE_CYCLES);
          state_next = ST_SETTLE;
        end
        ST_SETTLE: begin
          cnt_next = cnt_reg - 16'h0001;
          if (cnt_reg <= 16'h0001) begin
            state_next = ret_reg;
          end
        end
        ST_SHALLOW: begin
          if (thr_sync_reg) begin
            state_next = ST_LOCALC;                                       // [RL6]
          end else begin
            off_next   = 32'(32'h0 - SEARCH_SPAN);                        // [RL7]
            state_next = ST_SEARCH;
          end
        end
        ST_SEARCH: begin
          if (thr_sync_reg && ret_reg == ST_SEARCH) begin
            state_next = ST_LOCALC;
          end else if (ret_reg == ST_SEARCH && $signed(off_reg) >= $signed(SEARCH_SPAN)) begin
            fail_next  = 1'b1;                                            // [RL7]
            sup_next   = 1'b1;
            state_next = ST_IDLE;
          end else begin
            if (ret_reg == ST_SEARCH) begin
              off_next = 32'(off_reg + SEARCH_STEP);                      // [RL7]
            end
            tgt_next   = 32'(fin_reg + off_next);
            ret_next   = ST_SEARCH;
            state_next = ST_VCO;
          end
        end
        ST_LOCALC: begin
          lo_next     = 32'(vco_reg * div_w);                             // [RL11]
          locked_next = 1'b1;
          state_next  = ST_LOCKED;
        end
        ST_LOCKED: begin
          if (trk_reg) begin
            trk_take   = 1'b1;
            state_next = ST_TRACK;
          end
        end
        ST_TRACK: begin
          if (!thr_sync_reg) begin
            lost_next   = 1'b1;                                           // [RL9]
            locked_next = 1'b0;
            sup_next    = 1'b1;
            vco_next    = vsw_reg;
            state_next  = ST_HARM;                                        // [RL16]
          end else if (if2_reg > IF2_LOW_KHZ && if2_reg < IF2_HIGH_KHZ) begin
            state_next = ST_LOCALC;                                       // [RL8]
          end else begin
            tgt_next   = sign_reg ? 32'(lo_reg + if2_reg) : 32'(lo_reg - if2_reg); // [RL10]
            ret_next   = ST_LOCALC;
            state_next = ST_VCO;                                          // [RL8]
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      ret_reg <= ST_IDLE;
      harm_reg <= 8'h00;
      vco_reg <= REG_RESET;
      coarse_reg <= REG_RESET;
      fin_reg <= REG_RESET;
      tgt_reg <= REG_RESET;
      filt_reg <= REG_RESET;
      fbcd_reg <= REG_RESET;
      lo_reg <= REG_RESET;
      off_reg <= REG_RESET;
      cnt_reg <= 16'h0000;
      locked_reg <= 1'b0;
      lost_reg <= 1'b0;
      fail_reg <= 1'b0;
      padr_reg <= 16'h0000;
      pdat_reg <= 8'h00;
      pwe_reg <= 1'b0;
      fwe_reg <= 1'b0;
      sup_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      harm_reg <= harm_next;
      vco_reg <= vco_next;
      coarse_reg <= coarse_next;
      fin_reg <= fin_next;
      tgt_reg <= tgt_next;
      filt_reg <= filt_next;
      fbcd_reg <= fbcd_next;
      lo_reg <= lo_next;
      off_reg <= off_next;
      cnt_reg <= cnt_next;
      locked_reg <= locked_next;
      lost_reg <= lost_next;
      fail_reg <= fail_next;
      padr_reg <= padr_next;
      pdat_reg <= pdat_next;
      pwe_reg <= pwe_next;
      fwe_reg <= fwe_next;
      sup_reg <= sup_next;
    end
  end

  assign wb_ack_o      = ack_reg;
  assign wb_dat_o      = dat_reg;
  assign prog_addr_o   = padr_reg;
  assign prog_data_o   = pdat_reg;
  assign prog_we_o     = pwe_reg;
  assign filter_freq_o = filt_reg;
  assign filter_we_o   = fwe_reg;
  assign supervisor_o  = sup_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_harm_number: assert property ((state_reg == ST_CENTRE) |->           // [RL1]
    32'(harm_reg) == 32'(ifd_reg + (step12 >> 1)) / step12)
    else $error("harmonic number mismatch");
  a_coarse_prod: assert property ((state_reg == ST_CENTRE) |->           // [RL2]
    coarse_reg == 32'(32'(harm_reg * HARM_FACTOR) * vco_reg))
    else $error("coarse product mismatch");
  a_filter_bcd: assert property ((state_reg == ST_FIN) |->               // [RL3]
    hltc_bcd_to_bin(fbcd_reg) == filt_reg)
    else $error("filter bcd does not match binary");
  a_filter_formula: assert property (filter_we_o |->                     // [RL12]
    filter_freq_o == 32'(32'(vco_reg << 1) + IF2_NOM_KHZ))
    else $error("filter not twice oscillator plus nominal");
  a_vco_grid: assert property ((state_reg == ST_TUNE) |->                // [RL13]
    (vco_reg % VCO_RES_KHZ) == 32'h0 && vco_reg <= VCO_MAX_KHZ)
    else $error("oscillator off grid or above limit");
  a_prog_order: assert property ((prog_we_o && prog_addr_o == PROG_ADR_HIGH) |=> // [RL15]
    prog_we_o && prog_addr_o == PROG_ADR_LOW ##1 !prog_we_o)
    else $error("program word not written high then low");
  a_shallow_exit: assert property ((state_reg == ST_SHALLOW && thr_sync_reg && !start_reg) |=> // [RL6]
    state_reg == ST_LOCALC ##1 locked_reg)
    else $error("shallow search did not exit on signal");
  a_search_span: assert property ((state_reg == ST_SEARCH) |->           // [RL7]
    $signed(off_reg) >= -$signed(SEARCH_SPAN) && $signed(off_reg) <= $signed(SEARCH_SPAN))
    else $error("search offset out of span");
  a_track_loss: assert property ((state_reg == ST_TRACK && !thr_sync_reg && !start_reg) |=> // [RL9]
    state_reg == ST_HARM && lost_reg && supervisor_o && !locked_reg)
    else $error("threshold loss did not restart locking");
  a_track_hold: assert property ((state_reg == ST_TRACK && thr_sync_reg && !start_reg
    && if2_reg > IF2_LOW_KHZ && if2_reg < IF2_HIGH_KHZ) |=> state_reg == ST_LOCALC) // [RL8]
    else $error("in-range IF caused a retune");
  a_lo_offset: assert property ((state_reg == ST_LOCKED && $past(state_reg) == ST_LOCALC) |-> // [RL11]
    lo_reg == 32'(vco_reg * div_w))
    else $error("offset not oscillator times divisor");

  c_locked:  cover property (state_reg == ST_LOCALC ##1 locked_reg);
  c_search:  cover property (state_reg == ST_SEARCH ##1 state_reg == ST_VCO);
  c_lost:    cover property (state_reg == ST_TRACK ##1 lost_reg);
  c_retune:  cover property (state_reg == ST_TRACK ##1 state_reg == ST_VCO);

endmodule
`default_nettype wire

/* File: rtl/hltc_pkg.sv */
package hltc_pkg;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned SETTLE_US     = 100;
  localparam int unsigned SETTLE_CYC    = (SETTLE_US * (CLK_HZ / 1_000_000));

  localparam logic [7:0]  ADR_CTRL      = 8'h00;
  localparam logic [7:0]  ADR_STEP      = 8'h04;
  localparam logic [7:0]  ADR_IFDELTA   = 8'h08;
  localparam logic [7:0]  ADR_VCO       = 8'h0c;
  localparam logic [7:0]  ADR_TRACKIF   = 8'h10;
  localparam logic [7:0]  ADR_STATUS    = 8'h14;
  localparam logic [7:0]  ADR_HARM      = 8'h18;
  localparam logic [7:0]  ADR_LO        = 8'h1c;
  localparam logic [7:0]  ADR_FILTBCD   = 8'h20;

  localparam int unsigned CTRL_START    = 0;
  localparam int unsigned CTRL_SIGN     = 1;
  localparam int unsigned STAT_LOCKED   = 0;
  localparam int unsigned STAT_LOST     = 1;
  localparam int unsigned STAT_BUSY     = 2;
  localparam int unsigned STAT_FAIL     = 3;

  localparam logic [31:0] REG_RESET     = 32'h0000_0000;

  localparam logic [31:0] HARM_FACTOR   = 32'd12;
  localparam logic [31:0] HARM_OFFSET   = 32'd2;
  localparam logic [31:0] IF2_NOM_KHZ   = 32'd125000;
  localparam logic [31:0] IF2_LOW_KHZ   = 32'd115000;
  localparam logic [31:0] IF2_HIGH_KHZ  = 32'd135000;
  localparam logic [31:0] SEARCH_SPAN   = 32'd60000;
  localparam logic [31:0] SEARCH_STEP   = 32'd200;
  localparam logic [31:0] VCO_RES_KHZ   = 32'd50;
  localparam logic [31:0] VCO_MAX_KHZ   = 32'd500000;
  localparam logic [31:0] PROG_MULT     = 32'd5;
  localparam logic [31:0] FRAC_SCALE    = 32'd16;
  localparam logic [31:0] PROG_QUARTERS = 32'd1000 / (PROG_MULT * VCO_RES_KHZ);
  localparam logic [15:0] PROG_ADR_LOW  = 16'h9820;
  localparam logic [15:0] PROG_ADR_HIGH = 16'h9822;

  function automatic logic [31:0] hltc_bin_to_bcd(input logic [31:0] b);
    logic [31:0] d;
    d = '0;
    for (int i = 31; i >= 0; i--) begin
      for (int k = 0; k < 8; k++) begin
        if (d[4*k +: 4] > 4'h4) begin
          d[4*k +: 4] = d[4*k +: 4] + 4'h3;
        end
      end
      d = {d[30:0], b[i]};
    end
    return d;
  endfunction

  function automatic logic [31:0] hltc_bcd_to_bin(input logic [31:0] d);
    logic [31:0] v;
    v = '0;
    for (int k = 7; k >= 0; k--) begin
      v = 32'(v * 32'd10) + {28'h0, d[4*k +: 4]};
    end
    return v;
  endfunction

  function automatic logic [31:0] hltc_harm_div(input logic [7:0] n, input logic hi_side);
    logic [31:0] m;
    m = 32'({24'h0, n} * HARM_FACTOR);
    return hi_side ? 32'(m + HARM_OFFSET) : 32'(m - HARM_OFFSET);
  endfunction

  function automatic logic [31:0] hltc_round50(input logic [31:0] x);
    return 32'((32'(x + (VCO_RES_KHZ >> 1)) / VCO_RES_KHZ) * VCO_RES_KHZ);
  endfunction

  function automatic logic [31:0] hltc_wmask(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction

endpackage

/* File: rtl/hltc_prog_word.sv */
`timescale 1ns/100ps
`default_nettype none
module hltc_prog_word
  import hltc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] freq_khz_i,
  output logic      [15:0] word_o
);

  logic [31:0] quarters;
  logic [31:0] digits;
  logic [31:0] frac16;
  logic [3:0]  lead;
  logic [15:0] word_next;
  logic [15:0] word_reg;

  // freq on the 50 khz grid; quarters counts freq*5 in units of 0.25
  always_comb begin
    quarters  = 32'(freq_khz_i / VCO_RES_KHZ);                          // [RL14]
    digits    = hltc_bin_to_bcd(32'(quarters / PROG_QUARTERS));
    frac16    = 32'(32'(quarters % PROG_QUARTERS) * FRAC_SCALE / PROG_QUARTERS);
    lead      = 4'(32'({28'h0, digits[15:12]}) + frac16);                // [RL14]
    word_next = {lead, digits[11:0]};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_reg <= 16'h0000;
    end else begin
      word_reg <= word_next;
    end
  end

  assign word_o = word_reg;

endmodule
`default_nettype wire

/* File: test/hltc_front_model.sv */
`timescale 1ns/100ps
`default_nettype none
module hltc_front_model
  import hltc_pkg::*;
#(
  parameter logic [15:0] LOCK_WORD  = 16'h6220,
  parameter logic [15:0] TRACK_WORD = 16'ha241,
  parameter logic [15:0] LOW_WORD   = 16'ha178
)(
  input  wire logic        clk_i,
  input  wire logic [15:0] prog_addr_i,
  input  wire logic [7:0]  prog_data_i,
  input  wire logic        prog_we_i,
  input  wire logic [31:0] filter_freq_i,
  input  wire logic        filter_we_i,
  input  wire logic        kill_i,
  output logic             if_threshold_o,
  output logic      [15:0] word_o,
  output logic      [31:0] filter_o
);
  logic [7:0] hi_reg = 8'h00;
  initial word_o = 16'h0000;
  initial filter_o = 32'h0000_0000;
  // the word only counts once both halves are in, as the oscillator latches on the low byte
  always @(posedge clk_i) begin
    if (prog_we_i && prog_addr_i == PROG_ADR_HIGH) hi_reg <= prog_data_i;
    if (prog_we_i && prog_addr_i == PROG_ADR_LOW) word_o <= {hi_reg, prog_data_i};
    if (filter_we_i) filter_o <= filter_freq_i;
  end
  // an IF appears only when the oscillator sits on a word that mixes with the input
  assign if_threshold_o = !kill_i && (word_o == LOCK_WORD || word_o == TRACK_WORD
                                      || word_o == LOW_WORD);
endmodule
`default_nettype wire

/* File: test/hltc_core_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module hltc_core_tb_top
  import hltc_pkg::*;
;
  logic        clk_i = 1'b0, rst_i = 1'b1, kill = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o, filter_freq_o, filt, d;
  logic        wb_ack_o, prog_we_o, filter_we_o, supervisor_o, thr;
  logic [15:0] prog_addr_o, word;
  logic [7:0]  prog_data_o;
  int          num_errors = 0, samples_checked = 0, cyc_cnt = 0;
  int          sup_cnt = 0, pw_cnt = 0, p0;

  always #50 clk_i = ~clk_i;

  hltc_core #(.SETTLE_CYCLES(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .if_threshold_i(thr),
    .prog_addr_o(prog_addr_o), .prog_data_o(prog_data_o), .prog_we_o(prog_we_o),
    .filter_freq_o(filter_freq_o), .filter_we_o(filter_we_o), .supervisor_o(supervisor_o));

  hltc_front_model fe (.clk_i(clk_i), .prog_addr_i(prog_addr_o), .prog_data_i(prog_data_o),
    .prog_we_i(prog_we_o), .filter_freq_i(filter_freq_o), .filter_we_i(filter_we_o),
    .kill_i(kill), .if_threshold_o(thr), .word_o(word), .filter_o(filt));

  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (supervisor_o === 1'b1) sup_cnt <= sup_cnt + 1;
    if (prog_we_o === 1'b1) pw_cnt <= pw_cnt + 1;
    if (cyc_cnt == 40000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // hold the request until ack is sampled high, then release
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hf;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] q;
    xfer(1'b1, a, v, q);
  endtask

  // poll until the wanted status bit is up with the sequencer idle
  task automatic wait_st(input int b, input int n);
    logic [31:0] q;
    repeat (3) @(posedge clk_i);
    q = 32'h0;
    for (int i = 0; i < n && !(q[b] === 1'b1 && q[STAT_BUSY] === 1'b0); i++)
      xfer(1'b0, ADR_STATUS, 32'h0, q);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    xfer(1'b0, ADR_STATUS, 32'h0, d);
    chk(d & 32'h8, 32'h8);
    chk(32'(sup_cnt), 32'd1);
    xfer(1'b0, 8'h40, 32'h0, d);
    chk(d, 32'h0);
    wr(ADR_STEP, 32'd1000);
    wr(ADR_IFDELTA, 32'd60000);
    wr(ADR_VCO, 32'd440000);
    p0 = pw_cnt;
    wr(ADR_CTRL, 32'h3);
    wait_st(STAT_LOCKED, 60);
    chk(32'(pw_cnt - p0), 32'd2);
    xfer(1'b0, ADR_HARM, 32'h0, d);
    chk(d, 32'd5);
    xfer(1'b0, ADR_VCO, 32'h0, d);
    chk(d, 32'd444050);
    chk({16'h0, word}, 32'h6220);
    chk(filt, 32'd1013100);
    xfer(1'b0, ADR_FILTBCD, 32'h0, d);
    chk(d, 32'h0101_3100);
    xfer(1'b0, ADR_LO, 32'h0, d);
    chk(d, 32'd27531100);
    p0 = pw_cnt;
    wr(ADR_TRACKIF, 32'd125000);
    wait_st(STAT_LOCKED, 20);
    chk(32'(pw_cnt - p0), 32'd0);
    wr(ADR_TRACKIF, 32'd140000);
    wait_st(STAT_LOCKED, 60);
    xfer(1'b0, ADR_VCO, 32'h0, d);
    chk(d, 32'd448300);
    chk({16'h0, word}, 32'ha241);
    chk(filt, 32'd1021600);
    xfer(1'b0, ADR_LO, 32'h0, d);
    chk(d, 32'd27794600);
    kill <= 1'b1;
    p0 = pw_cnt;
    wr(ADR_TRACKIF, 32'd125000);
    repeat (4) @(posedge clk_i);
    xfer(1'b0, ADR_STATUS, 32'h0, d);
    chk(d & 32'h3, 32'h2);
    chk(32'(sup_cnt), 32'd2);
    // relock finds nothing: one tune plus 601 search points, then hand back
    wait_st(STAT_FAIL, 6000);
    chk(32'(sup_cnt), 32'd3);
    chk(32'(pw_cnt - p0), 32'd1204);
    // low-side lock: every +/- term takes the minus branch
    kill <= 1'b0;
    wr(ADR_CTRL, 32'h1);
    wait_st(STAT_LOCKED, 60);
    xfer(1'b0, ADR_STATUS, 32'h0, d);
    chk(d & 32'hb, 32'h1);
    xfer(1'b0, ADR_VCO, 32'h0, d);
    chk(d, 32'd435700);
    chk({16'h0, word}, 32'ha178);
    chk(filt, 32'd996400);
    xfer(1'b0, ADR_LO, 32'h0, d);
    chk(d, 32'd25270600);
    // start frequency that pushes the corrected oscillator past its ceiling
    wr(ADR_VCO, 32'd500000);
    p0 = pw_cnt;
    wr(ADR_CTRL, 32'h3);
    wait_st(STAT_FAIL, 20);
    xfer(1'b0, ADR_STATUS, 32'h0, d);
    chk(d & 32'h9, 32'h8);
    chk(32'(pw_cnt - p0), 32'd0);
    chk(32'(sup_cnt), 32'd4);
    end_of_test();
  end
endmodule
`default_nettype wire
